// file: shared/sxt_pkg.sv
`default_nettype none

// ---------------------------------------------------------------
// Shared constants and types of the skip / table / xor unit
// ---------------------------------------------------------------
package sxt_pkg;

  // Data path and program memory shape
  localparam int DATA_W  = 8;
  localparam int PROG_W  = 16;
  localparam int PAGE_W  = 4;
  localparam int OFS_W   = 8;
  localparam int PROG_AW = PAGE_W + OFS_W;
  localparam int BIT_W   = 3;

  // Field positions inside a program word
  localparam int PW_LO_MSB = 7;
  localparam int PW_LO_LSB = 0;
  localparam int PW_HI_MSB = 15;
  localparam int PW_HI_LSB = 8;

  // Final program page
  localparam logic [PAGE_W-1:0] LAST_PAGE = 4'hf;

  // Reset values
  localparam logic [DATA_W-1:0]  DATA_RST  = 8'h00;
  localparam logic [PROG_AW-1:0] ADDR_RST  = 12'h000;

  // Instruction cycles taken by skip and table reads
  localparam int LONG_CYCLES = 2;

  // Operation selected by the core decoder
  typedef enum logic [3:0] {
    OP_NOP                      = 4'h0,
    OP_SKIP_IF_MEM_NULL         = 4'h1,
    OP_SKIP_IF_NULL_COPY_ACC    = 4'h2,
    OP_SKIP_IF_BIT_NULL         = 4'h3,
    OP_TABLE_READ_SPECIFIC_PAGE = 4'h4,
    OP_TABLE_READ_CURRENT_PAGE  = 4'h5,
    OP_TABLE_READ_LAST_PAGE     = 4'h6,
    OP_XOR_TO_ACC               = 4'h7,
    OP_EXCLUSIVE_OR_TO_MEMORY   = 4'h8,
    OP_XOR_IMM_TO_ACC           = 4'h9
  } sxt_op_t;

  // Sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_TAB   = 3'b010,
    ST_DUMMY = 3'b100
  } sxt_state_t;

  // Skip-type decode, used in several places
  function automatic logic sxt_is_skip(input sxt_op_t op);
    return (op == OP_SKIP_IF_MEM_NULL) || (op == OP_SKIP_IF_NULL_COPY_ACC)
        || (op == OP_SKIP_IF_BIT_NULL);
  endfunction

  // Table-read decode
  function automatic logic sxt_is_table(input sxt_op_t op);
    return (op == OP_TABLE_READ_SPECIFIC_PAGE) || (op == OP_TABLE_READ_CURRENT_PAGE)
        || (op == OP_TABLE_READ_LAST_PAGE);
  endfunction

endpackage

`default_nettype wire

// file: design/sxt_eval.sv
`default_nettype none

// ---------------------------------------------------------------
// Combinational evaluator: skip test and xor result
// ---------------------------------------------------------------
module sxt_eval
  import sxt_pkg::*;
(
  // Operation and operands
  input  wire sxt_op_t          op,
  input  wire logic [DATA_W-1:0] mem_rdata,
  input  wire logic [DATA_W-1:0] acc,
  input  wire logic [DATA_W-1:0] imm,
  input  wire logic [BIT_W-1:0]  bit_sel,
  // Results
  output logic                   skip_cond,
  output logic [DATA_W-1:0]      xor_res,
  output logic                   xor_zero
);

  // Skip test: whole byte or one bit equal to zero
  always_comb begin
    unique case (op)
      OP_SKIP_IF_MEM_NULL:      skip_cond = (mem_rdata == DATA_RST);
      OP_SKIP_IF_NULL_COPY_ACC: skip_cond = (mem_rdata == DATA_RST);
      OP_SKIP_IF_BIT_NULL:      skip_cond = ~mem_rdata[bit_sel];
      default:                  skip_cond = 1'b0;
    endcase
  end

  // Immediate form uses the operand field, the others the data byte
  always_comb begin
    if (op == OP_XOR_IMM_TO_ACC) begin
      xor_res = acc ^ imm;
    end else begin
      xor_res = acc ^ mem_rdata;
    end
    xor_zero = (xor_res == DATA_RST);
  end

endmodule

`default_nettype wire

// file: design/sxt_exec.sv
`default_nettype none

// ---------------------------------------------------------------
// Skip, table read and xor execution unit
// ---------------------------------------------------------------

// Notes on behaviour
// - Skip-if-null skips the next instruction when the addressed byte is zero.
// - Every skip instruction takes two cycles, a dummy filling the second.
// - Copy variant loads the byte into the accumulator, skips when it is zero.
// - Bit test skips the next instruction when the selected bit is zero.
// - Specific-page read uses both table pointers; low byte to memory, high to latch.
// - Current-page read uses the program page and low pointer; same destinations.
// - Last-page read uses the final page and low pointer; same destinations.
// - Xor to accumulator stores acc xor byte in acc, zero flag only.
// - Xor to memory writes acc xor byte back to memory, zero flag only.
// - Immediate xor stores acc xor operand in acc, zero flag only.
module sxt_exec
  import sxt_pkg::*;
(
  // Clock, reset, enable
  input  wire logic               mclk,
  input  wire logic               nrst,
  input  wire logic               ce,
  // Issue from the decoder
  input  wire logic               issue,
  input  wire sxt_op_t            op,
  input  wire logic [BIT_W-1:0]   bit_sel,
  input  wire logic [DATA_W-1:0]  imm,
  // Operands from the core
  input  wire logic [DATA_W-1:0]  mem_rdata,
  input  wire logic [DATA_W-1:0]  acc,
  input  wire logic [OFS_W-1:0]   table_pointer_low,
  input  wire logic [PAGE_W-1:0]  table_pointer_high,
  input  wire logic [PAGE_W-1:0]  pc_page,
  // Program memory read port
  output logic                    prog_req,
  output logic [PROG_AW-1:0]      prog_addr,
  input  wire logic [PROG_W-1:0]  prog_rdata,
  // Write-back
  output logic                    acc_we,
  output logic [DATA_W-1:0]       acc_wdata,
  output logic                    mem_we,
  output logic [DATA_W-1:0]       mem_wdata,
  output logic                    zero_we,
  output logic                    zero_val,
  output logic [DATA_W-1:0]       table_high_latch,
  // Sequencing
  output logic                    skip_next,
  output logic                    done,
  output logic                    busy
);

  // ---------------------------------------------------------------
  // Evaluator
  // ---------------------------------------------------------------
  logic              skip_cond;
  logic [DATA_W-1:0] xor_res;
  logic              xor_zero;

  sxt_eval u_eval (
    .op        (op),
    .mem_rdata (mem_rdata),
    .acc       (acc),
    .imm       (imm),
    .bit_sel   (bit_sel),
    .skip_cond (skip_cond),
    .xor_res   (xor_res),
    .xor_zero  (xor_zero)
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  sxt_state_t        state,      next_state;
  logic              take;
  logic              next_prog_req;
  logic [PROG_AW-1:0] next_prog_addr;
  logic              next_acc_we,  next_mem_we,  next_zero_we, next_zero_val;
  logic [DATA_W-1:0] next_acc_wdata, next_mem_wdata, next_table_high_latch;
  logic              next_skip_next, next_done;

  // Issue only taken while idle; the decoder must hold off on busy
  assign busy = (state != ST_IDLE);
  assign take = issue && (state == ST_IDLE);

  // Next-state and write-back computation
  always_comb begin
    next_state     = state;
    next_prog_req  = 1'b0;
    next_prog_addr = prog_addr;
    next_acc_we    = 1'b0;
    next_acc_wdata = acc_wdata;
    next_mem_we    = 1'b0;
    next_mem_wdata = mem_wdata;
    next_zero_we   = 1'b0;
    next_zero_val  = zero_val;
    next_table_high_latch = table_high_latch;
    next_skip_next = 1'b0;
    next_done      = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (take) begin
          if (sxt_is_skip(op)) begin
            // Skip decision flagged now, dummy slot follows
            next_state     = ST_DUMMY;
            next_skip_next = skip_cond;
            if (op == OP_SKIP_IF_NULL_COPY_ACC) begin
              next_acc_we    = 1'b1;
              next_acc_wdata = mem_rdata;
            end
          end else if (sxt_is_table(op)) begin
            next_state    = ST_TAB;
            next_prog_req = 1'b1;
            unique case (op)
              OP_TABLE_READ_SPECIFIC_PAGE:
                next_prog_addr = {table_pointer_high, table_pointer_low};
              OP_TABLE_READ_CURRENT_PAGE:
                next_prog_addr = {pc_page, table_pointer_low};
              default:
                next_prog_addr = {LAST_PAGE, table_pointer_low};
            endcase
          end else if (op == OP_EXCLUSIVE_OR_TO_MEMORY) begin
            next_mem_we    = 1'b1;
            next_mem_wdata = xor_res;
            next_zero_we   = 1'b1;
            next_zero_val  = xor_zero;
            next_done      = 1'b1;
          end else if ((op == OP_XOR_TO_ACC) || (op == OP_XOR_IMM_TO_ACC)) begin
            next_acc_we    = 1'b1;
            next_acc_wdata = xor_res;
            next_zero_we   = 1'b1;
            next_zero_val  = xor_zero;
            next_done      = 1'b1;
          end else begin
            // No-op and unused codes complete without effect
            next_done = 1'b1;
          end
        end
      end
      ST_TAB: begin
        // Word arrives while the request stands; split it, no flag touched
        next_mem_we    = 1'b1;
        next_mem_wdata = prog_rdata[PW_LO_MSB:PW_LO_LSB];
        next_table_high_latch = prog_rdata[PW_HI_MSB:PW_HI_LSB];
        next_done      = 1'b1;
        next_state     = ST_IDLE;
      end
      ST_DUMMY: begin
        // Inserted dummy while the next word is fetched
        next_done  = 1'b1;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Registers; a low enable freezes everything, pulses included
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state            <= ST_IDLE;
      prog_req         <= 1'b0;
      prog_addr        <= ADDR_RST;
      acc_we           <= 1'b0;
      acc_wdata        <= DATA_RST;
      mem_we           <= 1'b0;
      mem_wdata        <= DATA_RST;
      zero_we          <= 1'b0;
      zero_val         <= 1'b0;
      table_high_latch <= DATA_RST;
      skip_next        <= 1'b0;
      done             <= 1'b0;
    end else if (ce) begin
      state            <= next_state;
      prog_req         <= next_prog_req;
      prog_addr        <= next_prog_addr;
      acc_we           <= next_acc_we;
      acc_wdata        <= next_acc_wdata;
      mem_we           <= next_mem_we;
      mem_wdata        <= next_mem_wdata;
      zero_we          <= next_zero_we;
      zero_val         <= next_zero_val;
      table_high_latch <= next_table_high_latch;
      skip_next        <= next_skip_next;
      done             <= next_done;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  // Checks are suspended while the enable is low, as state is frozen
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst || !ce);

  sequence s_take(sxt_op_t o);
    take && (op == o);
  endsequence

  sequence s_table_land;
    ##1 (mem_we && !zero_we && (mem_wdata == $past(prog_rdata[PW_LO_MSB:PW_LO_LSB]))
         && (table_high_latch == $past(prog_rdata[PW_HI_MSB:PW_HI_LSB])) && done);
  endsequence

  // Second slot of a long instruction: busy, then completion and idle
  sequence s_dummy_slot;
    busy && !done ##1 done && !busy;
  endsequence

  // A two-cycle instruction is accepted while idle
  sequence s_long_start;
    take && (sxt_is_skip(op) || sxt_is_table(op));
  endsequence

  AST_SKIP_NULL: assert property (
    s_take(OP_SKIP_IF_MEM_NULL) |=> (skip_next == ($past(mem_rdata) == DATA_RST))
  ) else $error("skip on null byte wrong");

  AST_TWO_CYCLES: assert property (
    take && sxt_is_skip(op) |=> s_dummy_slot
  ) else $error("skip did not take two cycles");

  AST_COPY_SKIP: assert property (
    s_take(OP_SKIP_IF_NULL_COPY_ACC) |=> acc_we && !mem_we
      && (acc_wdata == $past(mem_rdata)) && (skip_next == (acc_wdata == DATA_RST))
  ) else $error("copy skip wrong");

  AST_BIT_SKIP: assert property (
    s_take(OP_SKIP_IF_BIT_NULL) |=> !mem_we && (skip_next == !$past(mem_rdata[bit_sel]))
  ) else $error("bit skip wrong");

  AST_TAB_SPECIFIC: assert property (
    s_take(OP_TABLE_READ_SPECIFIC_PAGE) |=> prog_req
      && (prog_addr == {$past(table_pointer_high), $past(table_pointer_low)}) ##0 s_table_land
  ) else $error("specific page table read wrong");

  AST_TAB_CURRENT: assert property (
    s_take(OP_TABLE_READ_CURRENT_PAGE) |=> prog_req
      && (prog_addr == {$past(pc_page), $past(table_pointer_low)}) ##0 s_table_land
  ) else $error("current page table read wrong");

  AST_TAB_LAST: assert property (
    s_take(OP_TABLE_READ_LAST_PAGE) |=> prog_req
      && (prog_addr == {LAST_PAGE, $past(table_pointer_low)}) ##0 s_table_land
  ) else $error("last page table read wrong");

  AST_XOR_ACC: assert property (
    s_take(OP_XOR_TO_ACC) |=> acc_we && !mem_we && zero_we
      && (acc_wdata == ($past(acc) ^ $past(mem_rdata))) && (zero_val == (acc_wdata == DATA_RST))
  ) else $error("xor to acc wrong");

  AST_XOR_MEM: assert property (
    s_take(OP_EXCLUSIVE_OR_TO_MEMORY) |=> mem_we && !acc_we && zero_we
      && (mem_wdata == ($past(acc) ^ $past(mem_rdata))) && (zero_val == (mem_wdata == DATA_RST))
  ) else $error("xor to memory wrong");

  AST_XOR_IMM: assert property (
    s_take(OP_XOR_IMM_TO_ACC) |=> acc_we && zero_we
      && (acc_wdata == ($past(acc) ^ $past(imm))) && (zero_val == (acc_wdata == DATA_RST))
  ) else $error("immediate xor wrong");

  AST_NO_FLAGS: assert property (
    s_long_start |=> !zero_we ##1 !zero_we
  ) else $error("flag touched by skip or table read");

  // Table reads share the two-cycle shape; the fetch unit relies on it
  AST_TAB_TWO_CYCLES: assert property (
    take && sxt_is_table(op) |=> s_dummy_slot
  ) else $error("table read did not take two cycles");

  // The filler slot must have no side effect at all
  AST_DUMMY_QUIET: assert property (
    (state == ST_DUMMY) |=> done && !acc_we && !mem_we && !zero_we
      && !skip_next && !prog_req
  ) else $error("dummy slot had an effect");

  // Skips never write data memory, in either cycle
  AST_SKIP_NO_MEM: assert property (
    take && sxt_is_skip(op) |=> !mem_we ##1 !mem_we
  ) else $error("skip wrote data memory");

  // Table reads leave the accumulator alone, in either cycle
  AST_TAB_NO_ACC: assert property (
    take && sxt_is_table(op) |=> !acc_we ##1 !acc_we
  ) else $error("table read wrote the accumulator");

  // Latch moves only when a table word lands
  AST_LATCH_HOLD: assert property (
    (state != ST_TAB) |=> $stable(table_high_latch)
  ) else $error("table latch changed outside a table read");

  // Read request is a single pulse; a second one would refetch
  AST_REQ_PULSE: assert property (
    prog_req |=> !prog_req
  ) else $error("program read request longer than one cycle");

  // Xor forms finish at once, so the decoder can issue back to back
  AST_XOR_ONE_CYCLE: assert property (
    take && (op inside {OP_XOR_TO_ACC, OP_EXCLUSIVE_OR_TO_MEMORY, OP_XOR_IMM_TO_ACC})
      |=> done && !busy
  ) else $error("xor did not finish in one cycle");

endmodule

`default_nettype wire

// file: bench/sxt_exec_test.sv
`default_nettype none

// ---------------------------------------------------------------
// Self-checking bench of the skip / table / xor unit
// ---------------------------------------------------------------
module sxt_exec_test
  import sxt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Expected or observed outcome of one instruction
  typedef struct packed {
    logic               skip;
    logic               acc_we;
    logic [DATA_W-1:0]  acc_d;
    logic               mem_we;
    logic [DATA_W-1:0]  mem_d;
    logic               zero_we;
    logic               zero_v;
    logic               preq;
    logic [PROG_AW-1:0] paddr;
    logic [DATA_W-1:0]  tbh;
    logic [7:0]         lat;
    logic [15:0]        t0;
  } sxt_note_t;

  logic                  mclk = 1'b0;
  logic                  nrst = 1'b0;
  logic                  ce = 1'b1;
  logic                  issue = 1'b0;
  sxt_op_t               op = OP_NOP;
  logic [BIT_W-1:0]      bit_sel = 3'h0;
  logic [DATA_W-1:0]     imm = 8'h00;
  logic [DATA_W-1:0]     mem_rdata = 8'h00;
  logic [DATA_W-1:0]     acc = 8'h00;
  logic [OFS_W-1:0]      table_pointer_low = 8'h00;
  logic [PAGE_W-1:0]     table_pointer_high = 4'h0;
  logic [PAGE_W-1:0]     pc_page = 4'h0;
  logic [PROG_W-1:0]     prog_rdata = 16'h0000;
  logic                  prog_req;
  logic [PROG_AW-1:0]    prog_addr;
  logic                  acc_we;
  logic [DATA_W-1:0]     acc_wdata;
  logic                  mem_we;
  logic [DATA_W-1:0]     mem_wdata;
  logic                  zero_we;
  logic                  zero_val;
  logic [DATA_W-1:0]     table_high_latch;
  logic                  skip_next;
  logic                  done;
  logic                  busy;
  int                    seed = 15;
  int                    failures = 0;
  int                    checked = 0;
  logic [15:0]           cyc = 16'h0000;
  logic                  rnd_ce = 1'b0;
  logic [DATA_W-1:0]     tbh_model = DATA_RST;
  sxt_note_t             notes[$];
  sxt_note_t             got = '0;
  sxt_note_t             n;

  sxt_exec dut (
    .mclk(mclk), .nrst(nrst), .ce(ce), .issue(issue), .op(op), .bit_sel(bit_sel),
    .imm(imm), .mem_rdata(mem_rdata), .acc(acc), .table_pointer_low(table_pointer_low),
    .table_pointer_high(table_pointer_high), .pc_page(pc_page), .prog_req(prog_req),
    .prog_addr(prog_addr), .prog_rdata(prog_rdata), .acc_we(acc_we),
    .acc_wdata(acc_wdata), .mem_we(mem_we), .mem_wdata(mem_wdata), .zero_we(zero_we),
    .zero_val(zero_val), .table_high_latch(table_high_latch), .skip_next(skip_next),
    .done(done), .busy(busy)
  );

  always #5 mclk = ~mclk;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Program word pattern: every address bit lands somewhere visible
  function automatic logic [PROG_W-1:0] rom(input logic [PROG_AW-1:0] ad);
    return {~ad[7:0], ad[11:8], ad[3:0]};
  endfunction

  function automatic logic [31:0] wbv(input sxt_note_t x);
    return {12'h000, x.acc_we, x.acc_d, x.mem_we, x.mem_d, x.zero_we, x.zero_v};
  endfunction

  function automatic logic [31:0] tbv(input sxt_note_t x);
    return {11'h000, x.preq, x.paddr, x.tbh};
  endfunction

  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (e !== g) begin
      failures++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task automatic final_report();
    if (failures == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Issue one instruction, note its outcome, wait until busy clears
  task automatic run(input sxt_op_t o, input logic [7:0] m, input logic [7:0] a,
                     input logic [7:0] im, input logic [7:0] tpl, input logic [2:0] b,
                     input logic [3:0] tph, input logic [3:0] pg);
    sxt_note_t        e;
    logic [11:0]      ad;
    logic [15:0]      w;
    e = '0;
    ad = 12'h000;
    op = o; mem_rdata = m; acc = a; imm = im; bit_sel = b;
    table_pointer_low = tpl; table_pointer_high = tph; pc_page = pg; issue = 1'b1;
    ce = rnd_ce ? ($random(seed) % 3 != 0) : 1'b1;
    e.lat = 8'h01;
    e.t0 = cyc;
    e.tbh = tbh_model;
    case (o)
      OP_SKIP_IF_MEM_NULL: e.skip = (m == 8'h00);
      OP_SKIP_IF_NULL_COPY_ACC: begin
        e.skip = (m == 8'h00);
        e.acc_we = 1'b1;
        e.acc_d = m;
      end
      OP_SKIP_IF_BIT_NULL: e.skip = !m[b];
      OP_TABLE_READ_SPECIFIC_PAGE: ad = {tph, tpl};
      OP_TABLE_READ_CURRENT_PAGE: ad = {pg, tpl};
      OP_TABLE_READ_LAST_PAGE: ad = {LAST_PAGE, tpl};
      OP_XOR_TO_ACC: begin e.acc_we = 1'b1; e.acc_d = a ^ m; end
      OP_EXCLUSIVE_OR_TO_MEMORY: begin e.mem_we = 1'b1; e.mem_d = a ^ m; end
      OP_XOR_IMM_TO_ACC: begin e.acc_we = 1'b1; e.acc_d = a ^ im; end
      default: ;
    endcase
    if (o inside {OP_XOR_TO_ACC, OP_EXCLUSIVE_OR_TO_MEMORY, OP_XOR_IMM_TO_ACC}) begin
      e.zero_we = 1'b1;
      e.zero_v = ((e.acc_d | e.mem_d) == 8'h00);
    end
    if (o inside {[OP_SKIP_IF_MEM_NULL:OP_TABLE_READ_LAST_PAGE]}) e.lat = 8'(LONG_CYCLES);
    if (o inside {[OP_TABLE_READ_SPECIFIC_PAGE:OP_TABLE_READ_LAST_PAGE]}) begin
      w = rom(ad);
      e.preq = 1'b1;
      e.paddr = ad;
      e.mem_we = 1'b1;
      e.mem_d = w[7:0];
      e.tbh = w[15:8];
      tbh_model = w[15:8];
    end
    notes.push_back(e);
    // A stalled take gets one frozen cycle, then the enable returns
    forever begin
      @(posedge mclk);
      if (ce) break;
      @(negedge mclk);
      ce = 1'b1;
    end
    // Scramble op, data byte, acc and enable while busy: a held issue must be ignored
    forever begin
      @(negedge mclk);
      if (busy !== 1'b1) break;
      op = sxt_op_t'(4'($random(seed)));
      mem_rdata = 8'($random(seed));
      acc = 8'($random(seed));
      ce = rnd_ce ? ($random(seed) % 3 != 0) : 1'b1;
    end
  endtask

  // ---------------------------------------------------------------
  // Program memory and result monitor
  // ---------------------------------------------------------------
  // Word only while requested; otherwise a changing pattern
  always @(negedge mclk) begin
    prog_rdata <= prog_req ? rom(prog_addr) : 16'($random(seed));
  end

  // Gather pulses of one instruction, compare when done shows up
  always @(posedge mclk) begin
    if (!nrst) begin
      got = '0;
    end else if (ce) begin
      // Anything but a clean low is kept, so an unknown strobe fails the compare
      got.skip = got.skip | skip_next;
      if (acc_we !== 1'b0) begin got.acc_we = acc_we; got.acc_d = acc_wdata; end
      if (mem_we !== 1'b0) begin got.mem_we = mem_we; got.mem_d = mem_wdata; end
      if (zero_we !== 1'b0) begin got.zero_we = zero_we; got.zero_v = zero_val; end
      if (prog_req !== 1'b0) begin got.preq = prog_req; got.paddr = prog_addr; end
      if (done) begin
        got.tbh = table_high_latch;
        if (notes.size() == 0) begin
          chk(32'h0, 32'h1);
        end else begin
          n = notes.pop_front();
          got.lat = 8'(cyc - n.t0);
          chk(32'(n.skip), 32'(got.skip));
          chk(wbv(n), wbv(got));
          chk(tbv(n), tbv(got));
          chk(32'(n.lat), 32'(got.lat));
        end
        got = '0;
      end
      cyc = cyc + 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    nrst = 1'b1;
    // Every code with a null data byte, acc and immediate, then with non-null ones
    for (int i = 0; i < 16; i++) run(sxt_op_t'(4'(i)), 8'h00, 8'h00, 8'h00, 8'hff, 3'h7, 4'ha, 4'h3);
    for (int i = 0; i < 16; i++) run(sxt_op_t'(4'(i)), 8'h80, 8'h81, 8'h5a, 8'h00, 3'h0, 4'h5, 4'hc);
    // Each bit position, clear and set
    for (int b = 0; b < 8; b++) begin
      run(OP_SKIP_IF_BIT_NULL, 8'hff ^ (8'h01 << b), 8'h00, 8'h00, 8'h00, 3'(b), 4'h0, 4'h0);
      run(OP_SKIP_IF_BIT_NULL, 8'h01 << b, 8'h00, 8'h00, 8'h00, 3'(b), 4'h0, 4'h0);
    end
    // Random traffic with a wandering clock enable
    rnd_ce = 1'b1;
    repeat (300) begin
      run(sxt_op_t'(4'($random(seed))), 8'($random(seed)), 8'($random(seed)),
          8'($random(seed)), 8'($random(seed)), 3'($random(seed)),
          4'($random(seed)), 4'($random(seed)));
    end
    issue = 1'b0;
    ce = 1'b1;
    repeat (5) @(negedge mclk);
    chk(32'h0, 32'(notes.size()));
    final_report();
  end

  // Watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge mclk);
    failures++;
    final_report();
  end

endmodule

`default_nettype wire
